// File: ctp_pkg.sv
// package of types and constants for the compact test port
// assumes nothing beyond a SystemVerilog compiler
package ctp_pkg;

  // sixteen states of the internal test access controller
  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SHF_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHF_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } ctp_tap_type;

  // check packet progress
  typedef enum logic [1:0] {CP_IDLE, CP_PRE, CP_BODY} ctp_cp_type;

  // protocol mode of the port
  typedef enum logic {MODE_STD, MODE_ADV} ctp_mode_type;

  // counter width and default element lengths, in link clock edges
  localparam int            CNT_W         = 4;
  localparam logic [3:0]    PRE_EDGES     = 4'h4;
  localparam logic [3:0]    BODY_EDGES    = 4'h8;
  localparam logic [3:0]    ADV_EDGES     = 4'h6;
  localparam logic [3:0]    CNT_RST       = 4'h0;
  // link clock period in the bench, sampled by the 4 ns system clock
  localparam int            TCK_PERIOD_NS = 32;
  localparam int            SYS_PERIOD_NS = 4;
  localparam int            TCK_CYCLES    = TCK_PERIOD_NS / SYS_PERIOD_NS;

endpackage

// File: ctp_port.sv
// compact two-pin test port: check packet hold and protocol mode
// assumes tck and tms come from the pins, asynchronous to sys_clk;
// cp_start, adv_req and self_rst come from sys_clk logic
`timescale 1ns/1ps
module ctp_port
  import ctp_pkg::*;
#(
  parameter logic [CNT_W-1:0] PRE_LEN  = PRE_EDGES,
  parameter logic [CNT_W-1:0] BODY_LEN = BODY_EDGES,
  parameter logic [CNT_W-1:0] ADV_LEN  = ADV_EDGES
)
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // link pins
  input  wire logic         tck,
  input  wire logic         tms,
  // protocol requests
  input  wire logic         cp_start,
  input  wire logic         adv_req,
  input  wire logic         self_rst,
  // status
  output ctp_tap_type       tap_state,
  output logic              tap_tck,
  output logic              cp_busy,
  output logic              adv_mode,
  output logic              adv_pend
);

  // ************************************************
  // pin synchronisers
  // ************************************************

  logic tck_s1_r;
  logic tck_s2_r;
  logic tck_d_r;
  logic tms_s1_r;
  logic tms_s2_r;

  // two flops per pin, plus a delay flop on tck; the first stage only feeds the second
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_d_r  <= 1'b0;
      tms_s1_r <= 1'b1;
      tms_s2_r <= 1'b1;
    end
    else
    begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r  <= tck_s2_r;
      tms_s1_r <= tms;
      tms_s2_r <= tms_s1_r;
    end
  end

  // rising edge of the link clock, seen two cycles late
  wire tck_rise = tck_s2_r & ~tck_d_r;

  // ************************************************
  // check packet sequencing
  // ************************************************

  ctp_tap_if  tap_if ();

  ctp_cp_type           cp_st_r;
  ctp_cp_type           cp_st_nxt;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic                 hold_r;
  logic                 open_r;
  logic                 tap_tck_r;

  // start from idle only
  // a packet may only start from idle, so holding keeps it idle
  wire cp_go     = cp_start & (cp_st_r == CP_IDLE) &
                   (tap_if.state == TAP_RTI);
  wire pre_last  = (cnt_r == PRE_LEN - 1'b1);
  wire body_last = (cnt_r == BODY_LEN - 1'b1);
  wire cnt_end   = (cp_st_r == CP_PRE) ? pre_last : body_last;

  // element sequencer
  always_comb
  begin
    cp_st_nxt = cp_st_r;
    cnt_nxt   = cnt_r;
    case (cp_st_r)
      CP_IDLE:
      begin
        cnt_nxt = CNT_RST;
        if (cp_go)
          cp_st_nxt = CP_PRE;
      end
      CP_PRE, CP_BODY:
      begin
        if (tck_rise && cnt_end)
        begin
          cnt_nxt   = CNT_RST;
          cp_st_nxt = (cp_st_r == CP_PRE) ? CP_BODY : CP_IDLE;
        end
        else if (tck_rise)
          cnt_nxt = cnt_r + 1'b1;
      end
      default:
      begin
        cp_st_nxt = CP_IDLE;
        cnt_nxt   = CNT_RST;
      end
    endcase
  end

  // one hold level across both elements, no gap at handover
  wire hold_nxt = (cp_st_nxt != CP_IDLE);

  // gate reopens while the link clock is low, like a latch gate, or at once on self_rst
  wire open_nxt = ~hold_nxt & (open_r | ~tck_s2_r);

  // edges reach the controller only through the open gate
  assign tap_if.step = tck_rise & open_r & ~cp_go;
  assign tap_if.tms  = tms_s2_r;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cp_st_r <= CP_IDLE;
      cnt_r   <= CNT_RST;
      hold_r  <= 1'b0;
      open_r  <= 1'b1;
    end
    else if (self_rst)
    begin
      cp_st_r <= CP_IDLE;
      cnt_r   <= CNT_RST;
      hold_r  <= 1'b0;
      open_r  <= 1'b1;
    end
    else
    begin
      cp_st_r <= cp_st_nxt;
      cnt_r   <= cnt_nxt;
      hold_r  <= hold_nxt;
      open_r  <= open_nxt;
    end
  end

  // gated clock from a flop, never from raw gating
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      tap_tck_r <= 1'b0;
    else
      tap_tck_r <= tck_s2_r & open_nxt & ~self_rst;
  end

  // ************************************************
  // protocol mode
  // ************************************************

  ctp_mode_type         mode_r;
  logic                 pend_r;
  logic [CNT_W-1:0]     adv_cnt_r;

  // switch completes after a fixed run of link edges
  wire adv_go   = adv_req & (mode_r == MODE_STD) & ~pend_r;
  wire adv_done = pend_r & tck_rise & (adv_cnt_r == ADV_LEN - 1'b1);

  // self-reset drops back to standard and aborts a switch
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_r    <= MODE_STD;
      pend_r    <= 1'b0;
      adv_cnt_r <= CNT_RST;
    end
    else if (self_rst)
    begin
      mode_r    <= MODE_STD;
      pend_r    <= 1'b0;
      adv_cnt_r <= CNT_RST;
    end
    else if (adv_go)
    begin
      pend_r    <= 1'b1;
      adv_cnt_r <= CNT_RST;
    end
    else if (adv_done)
    begin
      mode_r    <= MODE_ADV;
      pend_r    <= 1'b0;
      adv_cnt_r <= CNT_RST;
    end
    else if (pend_r && tck_rise)
      adv_cnt_r <= adv_cnt_r + 1'b1;
  end

  // ************************************************
  // controller and outputs
  // ************************************************

  ctp_tap u_tap (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .bus     (tap_if.tap)
  );

  assign tap_state = tap_if.state;
  assign tap_tck   = tap_tck_r;
  assign cp_busy   = hold_r;
  assign adv_mode  = (mode_r == MODE_ADV);
  assign adv_pend  = pend_r;

  // ************************************************
  // checks
  // ************************************************

  // handover from preamble to the body element
  sequence s_pre_to_body;
    cp_st_r == CP_PRE && cp_st_nxt == CP_BODY && !self_rst;
  endsequence

  sequence s_gate_shut;
    hold_r && !tap_tck_r && cp_st_r == CP_BODY;
  endsequence

  a_hold_no_step: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hold_r |-> !tap_if.step)
    else $error("link edge reached controller during a packet");

  a_handover_clean: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    s_pre_to_body |=> s_gate_shut)
    else $error("gated clock opened at preamble to body handover");

  a_gate_low_held: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hold_r && $past(hold_r) |-> !tap_tck_r)
    else $error("gated clock active while held");

  a_idle_kept: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    hold_r |-> tap_if.state == TAP_RTI && $stable(tap_if.state))
    else $error("controller left idle during a packet");

  a_self_rst_std: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    self_rst |=> mode_r == MODE_STD && !pend_r && cp_st_r == CP_IDLE
                 && cnt_r == CNT_RST && !hold_r)
    else $error("self-reset left port state behind");

  a_edge_steps: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    tck_rise && open_r && cp_st_r == CP_IDLE && !cp_start
      |-> tap_if.step)
    else $error("free link edge did not advance controller");

endmodule // ctp_port

// File: ctp_port_tb_top.sv
// self-checking bench for the compact test port
// assumes the tool model stands on the link pins
`timescale 1ns/1ps
module ctp_port_tb_top;
  import ctp_pkg::*;
  typedef struct packed
  {
    logic [3:0]  n;
    logic [7:0]  bits;
    ctp_tap_type st;
  } ctp_row_type;
  // ****************************
  // signals
  // ****************************
  logic        sys_clk = 1'b0;
  logic        rst_b;
  logic        tck;
  logic        tms;
  logic        cp_start;
  logic        adv_req;
  logic        self_rst;
  ctp_tap_type tap_state;
  logic        tap_tck;
  logic        cp_busy;
  logic        adv_mode;
  logic        adv_pend;
  int          fail_count;
  int          n_compared;
  int          hold_bad;
  int          cycles;
  int          tck_hi;
  // walks from test-logic-reset, bits applied lsb first
  ctp_row_type rows [16] = '{
    '{4'h1, 8'h00, TAP_RTI},    '{4'h2, 8'h02, TAP_SEL_DR},
    '{4'h3, 8'h02, TAP_CAP_DR}, '{4'h4, 8'h02, TAP_SHF_DR},
    '{4'h4, 8'h0a, TAP_EX1_DR}, '{4'h5, 8'h0a, TAP_PAU_DR},
    '{4'h6, 8'h2a, TAP_EX2_DR}, '{4'h5, 8'h1a, TAP_UPD_DR},
    '{4'h3, 8'h06, TAP_SEL_IR}, '{4'h4, 8'h06, TAP_CAP_IR},
    '{4'h5, 8'h06, TAP_SHF_IR}, '{4'h5, 8'h16, TAP_EX1_IR},
    '{4'h6, 8'h16, TAP_PAU_IR}, '{4'h7, 8'h56, TAP_EX2_IR},
    '{4'h6, 8'h36, TAP_UPD_IR}, '{4'h1, 8'h01, TAP_TLR}};

  always #2 sys_clk = ~sys_clk;

  ctp_tool_model tool (.tck(tck), .tms(tms));

  ctp_port #(.PRE_LEN(PRE_EDGES), .BODY_LEN(BODY_EDGES),
             .ADV_LEN(ADV_EDGES)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .tck(tck), .tms(tms),
    .cp_start(cp_start), .adv_req(adv_req), .self_rst(self_rst),
    .tap_state(tap_state), .tap_tck(tap_tck), .cp_busy(cp_busy),
    .adv_mode(adv_mode), .adv_pend(adv_pend));

  // any controller clock or state move inside a packet is a fault;
  // a gated clock that never pulses outside packets is one as well
  always @(posedge sys_clk)
  begin
    if (cp_busy === 1'b1 && (tap_tck !== 1'b0 || tap_state !== TAP_RTI))
      hold_bad++;
    if (cp_busy === 1'b0 && tap_tck === 1'b1)
      tck_hi++;
  end

  // hang guard, far above the roughly 1600 cycles the run needs
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ****************************
  // tasks
  // ****************************
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_st(input ctp_tap_type e);
    n_compared++;
    if (tap_state !== e)
    begin
      fail_count++;
      $display("ERROR tap_state expected %0d seen %0d", e, tap_state);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************
  // main sequence
  // ****************************
  initial
  begin
    {cp_start, adv_req, self_rst, rst_b} = 4'h0;
    {fail_count, n_compared, hold_bad, cycles, tck_hi} = '0;
    cyc(10);
    rst_b = 1'b1;
    chk_st(TAP_TLR);
    chk_bit("cp_busy", 1'b0, cp_busy);
    chk_bit("adv_mode", 1'b0, adv_mode);
    for (int r = 0; r < 16; r++)
    begin
      tool.send(8'h1f, 5);
      tool.send(rows[r].bits, int'(rows[r].n));
      cyc(4);
      chk_st(rows[r].st);
    end
    chk_bit("tap_tck_free", 1'b1, tck_hi > 0);
    // packet from idle, body tms high
    tool.send(8'h00, 1);
    cyc(4);
    cp_start = 1'b1;
    cyc(1);
    cp_start = 1'b0;
    chk_bit("cp_busy", 1'b1, cp_busy);
    tool.packet(1'b1);
    cyc(4);
    chk_bit("cp_busy", 1'b0, cp_busy);
    chk_st(TAP_RTI);
    chk_bit("hold_clean", 1'b1, hold_bad == 0);
    tool.send(8'h01, 1);
    cyc(4);
    chk_st(TAP_SEL_DR);
    // start outside idle is ignored
    cp_start = 1'b1;
    cyc(1);
    cp_start = 1'b0;
    chk_bit("cp_busy", 1'b0, cp_busy);
    // self-reset in mid-packet frees the controller
    tool.send(8'h1f, 6);
    cyc(1);
    cp_start = 1'b1;
    cyc(1);
    cp_start = 1'b0;
    tool.send(8'h00, 2);
    chk_bit("cp_busy", 1'b1, cp_busy);
    cyc(1);
    self_rst = 1'b1;
    cyc(1);
    self_rst = 1'b0;
    chk_bit("cp_busy", 1'b0, cp_busy);
    tool.send(8'h01, 1);
    cyc(4);
    chk_st(TAP_SEL_DR);
    // two aborted switches, third one lands
    // tool retries advanced mode
    for (int a = 0; a < 3; a++)
    begin
      adv_req = 1'b1;
      cyc(1);
      adv_req = 1'b0;
      chk_bit("adv_pend", 1'b1, adv_pend);
      tool.send(8'hff, (a < 2) ? 3 : 6);
      cyc(4);
      if (a < 2)
      begin
        self_rst = 1'b1;
        cyc(1);
        self_rst = 1'b0;
        chk_bit("adv_pend", 1'b0, adv_pend);
      end
      chk_bit("adv_mode", a == 2, adv_mode);
    end
    // self-reset drops advanced mode
    self_rst = 1'b1;
    cyc(1);
    self_rst = 1'b0;
    chk_bit("adv_mode", 1'b0, adv_mode);
    chk_bit("hold_clean", 1'b1, hold_bad == 0);
    finish_test();
  end
endmodule // ctp_port_tb_top

// File: ctp_tap.sv
// sixteen-state test access controller, advanced by step pulses
// assumes step and tms are already in the sys_clk domain
`timescale 1ns/1ps
module ctp_tap
  import ctp_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // port side
  ctp_tap_if.tap    bus
);

  ctp_tap_type state_r;
  ctp_tap_type state_nxt;

  // standard transition table
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      TAP_TLR:    state_nxt = bus.tms ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    state_nxt = bus.tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: state_nxt = bus.tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: state_nxt = bus.tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_SHF_DR: state_nxt = bus.tms ? TAP_EX1_DR : TAP_SHF_DR;
      TAP_EX1_DR: state_nxt = bus.tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: state_nxt = bus.tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: state_nxt = bus.tms ? TAP_UPD_DR : TAP_SHF_DR;
      TAP_UPD_DR: state_nxt = bus.tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: state_nxt = bus.tms ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: state_nxt = bus.tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_SHF_IR: state_nxt = bus.tms ? TAP_EX1_IR : TAP_SHF_IR;
      TAP_EX1_IR: state_nxt = bus.tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: state_nxt = bus.tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: state_nxt = bus.tms ? TAP_UPD_IR : TAP_SHF_IR;
      TAP_UPD_IR: state_nxt = bus.tms ? TAP_SEL_DR : TAP_RTI;
      default:    state_nxt = TAP_TLR;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= TAP_TLR;
    else if (bus.step)
      state_r <= state_nxt;
  end

  assign bus.state = state_r;

  a_tap_idle_exit: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    bus.step && bus.tms && state_r == TAP_RTI |=> state_r == TAP_SEL_DR)
    else $error("controller did not leave idle on high select");

  a_tap_no_step: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !bus.step |=> $stable(state_r))
    else $error("controller moved without a step");

endmodule // ctp_tap

// File: ctp_tap_if.sv
// interface between the port logic and the internal test controller
// assumes both ends run on sys_clk
`timescale 1ns/1ps
interface ctp_tap_if;
  import ctp_pkg::*;
  logic        step;   // one-cycle advance pulse
  logic        tms;    // synchronised mode select value
  ctp_tap_type state;  // controller state
  modport port (output step, output tms, input state);
  modport tap  (input step, input tms, output state);
endinterface

// File: ctp_tool_model.sv
// debug tool model: drives the link clock and mode select pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module ctp_tool_model
(
  // link pins
  output logic tck,
  output logic tms
);
  // ****************************
  // link bit timing
  // ****************************
  // clock stands low between frames, so no stray edge leaks out
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
  end

  // one bit per 32 ns period; tms only moves while tck is low
  task automatic send(input logic [7:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      tms = bits[i];
      #3 tck = 1'b1;
      #16 tck = 1'b0;
      #13;
    end
  endtask

  // body tms held at body_tms: when high, a leaky gate would walk the controller
  // preamble tms low
  task automatic packet(input logic body_tms);
    send(8'h00, 4);
    send({8{body_tms}}, 8);
  endtask
endmodule // ctp_tool_model
